//--- core/ivpm_params.svh
// Constants of the interrupt vector and priority map
// Overview of operation
// - Reset ranks highest, uses vector FFFEh-FFFFh and can wake from halt.
// - Software trap is non-maskable, uses FFFCh-FFFDh and gives no wake.
// - Source 0, port A group, uses FFFAh-FFFBh and wakes from halt.
// - Source 1, port B group, uses FFF8h-FFF9h and wakes from halt.
// - Port C lines 5..0 join group 0 or 1 by a one-time option.
// - Serial peripheral interrupt is source 3, FFF4h-FFF5h, wakes from halt.
// - First timer is source 4, FFF2h-FFF3h, never wakes from halt.
// - Clock time-base interrupt is source 5, FFF0h-FFF1h, wakes from halt.
// - Second timer is source 6 with vector FFEEh-FFEFh.
// - Supply detector is source 7, FFECh-FFEDh, never wakes from halt.
// - Asynchronous serial is source 10, FFE6h-FFE7h, never wakes from halt.
// - Hardware rank falls as source number rises; slots 2,8,9,12,13 unused.
// - Two-bit software priority per source in bytes 001Ch-001Fh, reset all ones.
`ifndef IVPM_PARAMS_SVH
`define IVPM_PARAMS_SVH

// ----------------------------------------------------------------
// Vector addresses (even address of each pair)
// ----------------------------------------------------------------
`define IVPM_VEC_RESET 16'hFFFE
`define IVPM_VEC_TRAP 16'hFFFC
`define IVPM_VEC_SRC0 16'hFFFA
`define IVPM_VEC_SRC1 16'hFFF8
`define IVPM_VEC_SRC2 16'hFFF6
`define IVPM_VEC_SRC3 16'hFFF4
`define IVPM_VEC_SRC4 16'hFFF2
`define IVPM_VEC_SRC5 16'hFFF0
`define IVPM_VEC_SRC6 16'hFFEE
`define IVPM_VEC_SRC7 16'hFFEC
`define IVPM_VEC_SRC8 16'hFFEA
`define IVPM_VEC_SRC9 16'hFFE8
`define IVPM_VEC_SRC10 16'hFFE6
`define IVPM_VEC_SRC11 16'hFFE4
`define IVPM_VEC_SRC12 16'hFFE2
`define IVPM_VEC_SRC13 16'hFFE0

// ----------------------------------------------------------------
// Source slots
// ----------------------------------------------------------------
`define IVPM_NSRC 14
`define IVPM_SRC_GRP0 4'h0
`define IVPM_SRC_GRP1 4'h1
`define IVPM_SRC_SPI 4'h3
`define IVPM_SRC_TMRA 4'h4
`define IVPM_SRC_CLK 4'h5
`define IVPM_SRC_TMRB 4'h6
`define IVPM_SRC_AUX 4'h7
`define IVPM_SRC_SCI 4'hA
`define IVPM_SRC_I2C 4'hB

// ----------------------------------------------------------------
// Software priority bytes
// ----------------------------------------------------------------
`define IVPM_PRIO_BASE 16'h001C
`define IVPM_PRIO_LAST 16'h001F
`define IVPM_PRIO_RST 8'hFF
`define IVPM_PRIO_B3_FIXED 8'hF0
`define IVPM_PRIO_OFS_W 2

`endif

//--- core/ivpm_pkg.sv
// Types of the interrupt vector and priority map
package ivpm_pkg;

    // Kind of the winning request, one-hot
    typedef enum logic [3:0] {
        IVPM_KIND_NONE = 4'b0001,
        IVPM_KIND_RESET = 4'b0010,
        IVPM_KIND_TRAP = 4'b0100,
        IVPM_KIND_MASK = 4'b1000
    } ivpm_kind_t;

endpackage : ivpm_pkg

//--- core/ivpm_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module ivpm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_i,             // System clock
    input wire logic rst_n_i,               // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_i,   // Pin levels
    output logic [WIDTH-1:0] sync_o         // Synchronised levels
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage is read by the second stage only
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : ivpm_sync

`default_nettype wire

//--- core/ivpm_top.sv
// Interrupt source mapping, priority ranking and vector selection
`timescale 1ns/1ps
`default_nettype none
`include "ivpm_params.svh"

module ivpm_top (
    input wire logic clk_sys_i,                 // Core clock, 200 MHz
    input wire logic rst_n_i,                   // Asynchronous reset, active low
    input wire logic reset_req_i,               // Reset sequencer request, level
    input wire logic trap_req_i,                // Software trap request, level
    input wire logic halt_i,                    // Core is in halt
    input wire logic int_mask_i,                // Global mask of maskable sources
    input wire logic pc_group_opt_i,            // Option: 0 port C to group 0, 1 to group 1
    input wire logic [7:0] pa_irq_i,            // Port A interrupt pins
    input wire logic [7:0] pb_irq_i,            // Port B interrupt pins
    input wire logic [5:0] pc_irq_i,            // Port C interrupt pins
    input wire logic spi_irq_i,                 // Serial peripheral request
    input wire logic tmra_irq_i,                // First timer request
    input wire logic clk_tb_irq_i,              // main_clock_timebase_unit request
    input wire logic tmrb_irq_i,                // Second timer request
    input wire logic aux_irq_i,                 // aux_supply_detector request
    input wire logic sci_irq_i,                 // Asynchronous serial request
    input wire logic i2c_irq_i,                 // I2C request
    input wire logic prio_we_i,                 // Priority byte write strobe
    input wire logic [15:0] prio_addr_i,        // Priority byte address
    input wire logic [7:0] prio_wdata_i,        // Priority byte write data
    output logic [7:0] prio_rdata_o,            // Priority byte read data
    output logic irq_pending_o,                 // Some request is pending
    output var ivpm_pkg::ivpm_kind_t kind_o,    // Kind of the winner
    output logic [3:0] src_o,                   // Maskable source number of winner
    output logic [15:0] vector_o,               // Even address of vector pair
    output logic wake_o                         // Wake from halt
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] pa_sync;
    logic [7:0] pb_sync;
    logic [5:0] pc_sync;

    ivpm_sync #(.WIDTH(8)) u_sync_pa (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(pa_irq_i),
        .sync_o(pa_sync)
    );

    ivpm_sync #(.WIDTH(8)) u_sync_pb (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(pb_irq_i),
        .sync_o(pb_sync)
    );

    ivpm_sync #(.WIDTH(6)) u_sync_pc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i(pc_irq_i),
        .sync_o(pc_sync)
    );

    // ----------------------------------------------------------------
    // Port C group option, caught once after reset release
    // ----------------------------------------------------------------
    // A strap must not reach an async reset value, so it is sampled here
    logic pc_opt_reg;
    logic pc_opt_done_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_opt_reg <= 1'b0;
            pc_opt_done_reg <= 1'b0;
        end
        else if (!pc_opt_done_reg)
        begin
            pc_opt_reg <= pc_group_opt_i;
            pc_opt_done_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // External groups
    // ----------------------------------------------------------------
    logic ext_irq_group_first;
    logic ext_irq_group_second;
    logic pc_any;

    assign pc_any = |pc_sync;
    // Port C is ignored until the option has been caught
    assign ext_irq_group_first = (|pa_sync) | (pc_any & pc_opt_done_reg & ~pc_opt_reg);
    assign ext_irq_group_second = (|pb_sync) | (pc_any & pc_opt_done_reg & pc_opt_reg);

    // ----------------------------------------------------------------
    // Maskable request slots
    // ----------------------------------------------------------------
    logic [`IVPM_NSRC-1:0] slot_req;

    always_comb
    begin
        slot_req = '0;
        slot_req[`IVPM_SRC_GRP0] = ext_irq_group_first;
        slot_req[`IVPM_SRC_GRP1] = ext_irq_group_second;
        slot_req[`IVPM_SRC_SPI] = spi_irq_i;
        slot_req[`IVPM_SRC_TMRA] = tmra_irq_i;
        slot_req[`IVPM_SRC_CLK] = clk_tb_irq_i;
        slot_req[`IVPM_SRC_TMRB] = tmrb_irq_i;
        slot_req[`IVPM_SRC_AUX] = aux_irq_i;
        slot_req[`IVPM_SRC_SCI] = sci_irq_i;
        slot_req[`IVPM_SRC_I2C] = i2c_irq_i;
    end

    // ----------------------------------------------------------------
    // Software priority bytes
    // ----------------------------------------------------------------
    logic [31:0] prio_reg;
    logic prio_hit;
    logic [`IVPM_PRIO_OFS_W-1:0] prio_ofs;

    assign prio_hit = (prio_addr_i >= `IVPM_PRIO_BASE) && (prio_addr_i <= `IVPM_PRIO_LAST);
    assign prio_ofs = prio_addr_i[`IVPM_PRIO_OFS_W-1:0];

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prio_reg <= {4{`IVPM_PRIO_RST}};
        end
        else if (prio_we_i && prio_hit)
        begin
            unique case (prio_ofs)
                2'h0: prio_reg[7:0] <= prio_wdata_i;
                2'h1: prio_reg[15:8] <= prio_wdata_i;
                2'h2: prio_reg[23:16] <= prio_wdata_i;
                // Upper nibble of the last byte holds no field and stays one
                2'h3: prio_reg[31:24] <= prio_wdata_i | `IVPM_PRIO_B3_FIXED;
            endcase
        end
    end

    // Read data registered, one cycle after the address
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prio_rdata_o <= 8'h00;
        end
        else if (prio_hit)
        begin
            unique case (prio_ofs)
                2'h0: prio_rdata_o <= prio_reg[7:0];
                2'h1: prio_rdata_o <= prio_reg[15:8];
                2'h2: prio_rdata_o <= prio_reg[23:16];
                2'h3: prio_rdata_o <= prio_reg[31:24];
            endcase
        end
        else
        begin
            prio_rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Vector table
    // ----------------------------------------------------------------
    function automatic logic [15:0] slot_vector(input logic [3:0] idx);
        logic [15:0] v;
        v = `IVPM_VEC_SRC13;
        unique case (idx)
            4'h0: v = `IVPM_VEC_SRC0;
            4'h1: v = `IVPM_VEC_SRC1;
            4'h2: v = `IVPM_VEC_SRC2;
            4'h3: v = `IVPM_VEC_SRC3;
            4'h4: v = `IVPM_VEC_SRC4;
            4'h5: v = `IVPM_VEC_SRC5;
            4'h6: v = `IVPM_VEC_SRC6;
            4'h7: v = `IVPM_VEC_SRC7;
            4'h8: v = `IVPM_VEC_SRC8;
            4'h9: v = `IVPM_VEC_SRC9;
            4'hA: v = `IVPM_VEC_SRC10;
            4'hB: v = `IVPM_VEC_SRC11;
            4'hC: v = `IVPM_VEC_SRC12;
            4'hD: v = `IVPM_VEC_SRC13;
            default: v = `IVPM_VEC_SRC13;
        endcase
        return v;
    endfunction : slot_vector

    // ----------------------------------------------------------------
    // Ranking among maskable sources
    // ----------------------------------------------------------------
    // Higher software level wins; equal levels fall to the lower number
    logic best_found;
    logic [1:0] best_lvl;
    logic [3:0] best_idx;

    always_comb
    begin
        best_found = 1'b0;
        best_lvl = 2'b00;
        best_idx = 4'h0;
        for (int i = 0; i < `IVPM_NSRC; i++)
        begin
            if (slot_req[i] && (!best_found || (prio_reg[2*i +: 2] > best_lvl)))
            begin
                best_found = 1'b1;
                best_lvl = prio_reg[2*i +: 2];
                best_idx = i[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Overall winner
    // ----------------------------------------------------------------
    logic trap_eff;
    logic mask_eff;
    ivpm_pkg::ivpm_kind_t kind_next;
    logic [3:0] src_next;
    logic [15:0] vector_next;

    // A trap needs a running core, so it is dropped while halted
    assign trap_eff = trap_req_i & ~halt_i;
    assign mask_eff = best_found & ~int_mask_i;

    always_comb
    begin
        kind_next = ivpm_pkg::IVPM_KIND_NONE;
        src_next = 4'h0;
        vector_next = vector_o;
        if (reset_req_i)
        begin
            kind_next = ivpm_pkg::IVPM_KIND_RESET;
            vector_next = `IVPM_VEC_RESET;
        end
        else if (trap_eff)
        begin
            kind_next = ivpm_pkg::IVPM_KIND_TRAP;
            vector_next = `IVPM_VEC_TRAP;
        end
        else if (mask_eff)
        begin
            kind_next = ivpm_pkg::IVPM_KIND_MASK;
            src_next = best_idx;
            vector_next = slot_vector(best_idx);
        end
    end

    // Vector holds its last value when nothing is pending
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            kind_o <= ivpm_pkg::IVPM_KIND_RESET;
            src_o <= 4'h0;
            vector_o <= `IVPM_VEC_RESET;
        end
        else
        begin
            kind_o <= kind_next;
            src_o <= src_next;
            vector_o <= vector_next;
        end
    end

    assign irq_pending_o = (kind_o != ivpm_pkg::IVPM_KIND_NONE);

    // ----------------------------------------------------------------
    // Wake from halt
    // ----------------------------------------------------------------
    // Wake ignores the global mask; the core decides whether to vector
    logic wake_next;

    assign wake_next = reset_req_i
        | slot_req[`IVPM_SRC_GRP0]
        | slot_req[`IVPM_SRC_GRP1]
        | slot_req[`IVPM_SRC_SPI]
        | slot_req[`IVPM_SRC_CLK];

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wake_o <= 1'b1;
        end
        else
        begin
            wake_o <= halt_i & wake_next;
        end
    end

endmodule : ivpm_top

`default_nettype wire

//--- bench/ivpm_monitor.sv
// Checker of the ranking, vector and wake outputs
`timescale 1ns/1ps
`default_nettype none

module ivpm_monitor (
    input wire logic clk_sys_i,             // Clock
    input wire logic rst_n_i,               // Reset
    input wire logic reset_req_i,           // Reset request
    input wire logic trap_req_i,            // Trap request
    input wire logic halt_i,                // Halted
    input wire logic int_mask_i,            // Global mask
    input wire logic spi_irq_i,             // Serial peripheral
    input wire logic [15:0] prio_addr_i,    // Priority address
    input wire logic [7:0] prio_rdata_o,    // Priority read data
    input var ivpm_pkg::ivpm_kind_t kind_o, // Winner kind
    input wire logic [3:0] src_o,           // Winner source
    input wire logic [15:0] vector_o,       // Winner vector
    input wire logic wake_o                 // Wake
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking mon_cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence trap_go_s;
        !reset_req_i && trap_req_i && !halt_i;
    endsequence
    sequence mask_win_s;
        kind_o == ivpm_pkg::IVPM_KIND_MASK;
    endsequence

    rst_vector_a: assert property (reset_req_i |=> kind_o == ivpm_pkg::IVPM_KIND_RESET && vector_o == 16'hFFFE)
        else $error("reset request lost its vector");
    rst_wake_a: assert property (reset_req_i && halt_i |=> wake_o)
        else $error("reset request gave no wake");
    trap_vector_a: assert property (trap_go_s |=> kind_o == ivpm_pkg::IVPM_KIND_TRAP && vector_o == 16'hFFFC)
        else $error("trap lost its vector");
    trap_halt_a: assert property (halt_i && !reset_req_i |=> kind_o != ivpm_pkg::IVPM_KIND_TRAP)
        else $error("trap taken while halted");
    spi_wake_a: assert property (halt_i && spi_irq_i |=> wake_o)
        else $error("serial peripheral gave no wake");
    spi_slot_a: assert property (mask_win_s ##0 src_o == 4'h3 |-> $past(spi_irq_i))
        else $error("slot 3 won without its request");
    mask_vector_a: assert property (mask_win_s |-> vector_o == 16'hFFFA - {11'h000, src_o, 1'b0})
        else $error("vector does not match source");
    empty_slot_a: assert property (mask_win_s |-> !(src_o inside {4'h2, 4'h8, 4'h9, 4'hC, 4'hD}))
        else $error("unused slot won");
    masked_a: assert property (int_mask_i |=> kind_o != ivpm_pkg::IVPM_KIND_MASK)
        else $error("masked source won");
    wake_halt_a: assert property ($past(rst_n_i) && wake_o |-> $past(halt_i))
        else $error("wake while running");
    rdata_zero_a: assert property (!(prio_addr_i inside {[16'h001C:16'h001F]}) |=> prio_rdata_o == 8'h00)
        else $error("unmapped priority read not zero");
endmodule : ivpm_monitor

bind ivpm_top ivpm_monitor ivpm_monitor_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reset_req_i(reset_req_i), .trap_req_i(trap_req_i),
    .halt_i(halt_i), .int_mask_i(int_mask_i), .spi_irq_i(spi_irq_i), .prio_addr_i(prio_addr_i),
    .prio_rdata_o(prio_rdata_o), .kind_o(kind_o), .src_o(src_o), .vector_o(vector_o), .wake_o(wake_o)
);

`default_nettype wire

//--- bench/ivpm_periph_model.sv
// Peripheral request lines held until the core serves their vector
`timescale 1ns/1ps
`default_nettype none

module ivpm_periph_model (
    input wire logic clk_sys_i,      // Clock
    input wire logic rst_n_i,        // Reset
    input wire logic [6:0] raise_i,  // Set: spi,tmra,clk,tmrb,aux,sci,i2c
    input wire logic [2:0] lat_i,    // Service delay, 0 prompt
    input wire logic [3:0] kind_i,   // Winner kind
    input wire logic [3:0] src_i,    // Winner source
    output logic [6:0] req_o         // Request levels
);
    // ----------------------------------------------------------------
    // Service
    // ----------------------------------------------------------------
    logic [2:0] wait_reg;
    logic [6:0] served;

    always_comb
    begin
        case (src_i)
            4'h3: served = 7'h01;
            4'h4: served = 7'h02;
            4'h5: served = 7'h04;
            4'h6: served = 7'h08;
            4'h7: served = 7'h10;
            4'hA: served = 7'h20;
            4'hB: served = 7'h40;
            default: served = 7'h00;
        endcase
    end

    // Stale winner may be cleared twice; harmless for level requests
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_o <= 7'h00;
            wait_reg <= 3'h0;
        end
        else if (kind_i == ivpm_pkg::IVPM_KIND_MASK && wait_reg >= lat_i)
        begin
            req_o <= (req_o & ~served) | raise_i;
            wait_reg <= 3'h0;
        end
        else
        begin
            req_o <= req_o | raise_i;
            wait_reg <= (kind_i == ivpm_pkg::IVPM_KIND_MASK) ? wait_reg + 3'h1 : 3'h0;
        end
    end
endmodule : ivpm_periph_model

`default_nettype wire

//--- bench/tb_ivpm_top.sv
// Self-checking bench of the interrupt vector and priority map
`timescale 1ns/1ps
`default_nettype none

module tb_ivpm_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam logic [3:0] kn = ivpm_pkg::IVPM_KIND_NONE;
    localparam logic [3:0] kr = ivpm_pkg::IVPM_KIND_RESET;
    localparam logic [3:0] kt = ivpm_pkg::IVPM_KIND_TRAP;
    localparam logic [3:0] km = ivpm_pkg::IVPM_KIND_MASK;
    logic clk_sys_i, rst_n_i, reset_req_i, trap_req_i, halt_i, int_mask_i, pc_group_opt_i, prio_we_i, wake_o, pend;
    logic [7:0] pa_irq_i, pb_irq_i, prio_wdata_i, prio_rdata_o;
    logic [5:0] pc_irq_i;
    logic [15:0] prio_addr_i, vector_o, rnd;
    logic [3:0] src_o;
    logic [6:0] raise, preq;
    logic [2:0] lat;
    ivpm_pkg::ivpm_kind_t kind_o;
    logic [24:0] exp_q[$];
    logic [24:0] cur, prev, ex;
    int errors, check_count;
    int srcs[7] = '{3, 4, 5, 6, 7, 10, 11};

    ivpm_top ivpm_top_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reset_req_i(reset_req_i), .trap_req_i(trap_req_i),
        .halt_i(halt_i), .int_mask_i(int_mask_i), .pc_group_opt_i(pc_group_opt_i), .pa_irq_i(pa_irq_i),
        .pb_irq_i(pb_irq_i), .pc_irq_i(pc_irq_i), .spi_irq_i(preq[0]), .tmra_irq_i(preq[1]),
        .clk_tb_irq_i(preq[2]), .tmrb_irq_i(preq[3]), .aux_irq_i(preq[4]), .sci_irq_i(preq[5]),
        .i2c_irq_i(preq[6]), .prio_we_i(prio_we_i), .prio_addr_i(prio_addr_i), .prio_wdata_i(prio_wdata_i),
        .prio_rdata_o(prio_rdata_o), .irq_pending_o(pend), .kind_o(kind_o), .src_o(src_o), .vector_o(vector_o),
        .wake_o(wake_o)
    );
    ivpm_periph_model ivpm_periph_model_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .raise_i(raise), .lat_i(lat), .kind_i(kind_o),
        .src_i(src_o), .req_o(preq)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] xs(input logic [15:0] s);
        logic [15:0] t;
        t = s ^ (s << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction : xs

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // First expected change goes ahead of any follow-ups queued by the caller
    task automatic step(input logic [24:0] e, input logic [7:0] a, input logic [7:0] b, input logic [5:0] c,
                        input logic [6:0] r);
        int n;
        exp_q.push_front(e);
        {pa_irq_i, pb_irq_i, pc_irq_i, raise} = {a, b, c, r};
        @(negedge clk_sys_i);
        raise = 7'h00;
        for (n = 0; n < 60 && exp_q.size() != 0; n++)
            @(negedge clk_sys_i);
        repeat (6) @(negedge clk_sys_i);
        check_count++;
        if (exp_q.size() != 0)
        begin
            errors++;
            $display("[ERR] pending expected 0 seen %0d", exp_q.size());
            exp_q.delete();
        end
    endtask : step

    task automatic prio(input logic [15:0] a, input logic we, input logic [7:0] d);
        // Strobe is set by every call, so back to back writes never toggle it twice at once
        {prio_addr_i, prio_we_i, prio_wdata_i} = {a, we, d};
        @(negedge clk_sys_i);
        if (!we)
        begin
            check_count++;
            if (prio_rdata_o !== d)
            begin
                errors++;
                $display("[ERR] prio_rdata_o expected %h seen %h", d, prio_rdata_o);
            end
        end
    endtask : prio

    // ----------------------------------------------------------------
    // Clock, watcher, watchdog
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    initial
    begin
        forever
        begin
            @(posedge clk_sys_i);
            #1;
            cur = {kind_o, src_o, vector_o, wake_o};
            if (!rst_n_i)
                prev = cur;
            else if (cur !== prev)
            begin
                prev = cur;
                ex = (exp_q.size() != 0) ? exp_q.pop_front() : 25'h0;
                check_count++;
                if (cur !== ex)
                begin
                    errors++;
                    $display("[ERR] outputs expected %h seen %h", ex, cur);
                end
                check_count++;
                if (pend !== (ex[24:21] != kn))
                begin
                    errors++;
                    $display("[ERR] irq_pending_o expected %0d seen %0d", ex[24:21] != kn, pend);
                end
            end
        end
    end

    initial
    begin
        repeat (6000) @(posedge clk_sys_i);
        errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        {rst_n_i, reset_req_i, trap_req_i, halt_i, int_mask_i, pc_group_opt_i, prio_we_i} = 7'h00;
        {pa_irq_i, pb_irq_i, pc_irq_i, prio_addr_i, prio_wdata_i, raise, lat} = '0;
        rnd = 16'h0040;
        repeat (20) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        step({kn, 4'h0, 16'hFFFE, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        // All peripherals at once while halted, served promptly
        halt_i = 1'b1;
        for (int i = 1; i < 7; i++)
            exp_q.push_back({km, 4'(srcs[i]), 16'hFFFA - 16'(2 * srcs[i]), i < 3});
        exp_q.push_back({kn, 4'h0, 16'hFFE4, 1'b0});
        step({km, 4'h3, 16'hFFF4, 1'b1}, 8'h00, 8'h00, 6'h00, 7'h7F);
        halt_i = 1'b0;
        prio(16'h001D, 1'b1, 8'h00);
        prio(16'h0020, 1'b1, 8'h00);
        prio(16'h001F, 1'b1, 8'h00);
        prio(16'h001D, 1'b0, 8'h00);
        prio(16'h001E, 1'b0, 8'hFF);
        prio(16'h001F, 1'b0, 8'hF0);
        prio(16'h0020, 1'b0, 8'h00);
        // Lowered first timer loses to the last source; slow service
        lat = 3'h3;
        exp_q.push_back({km, 4'h4, 16'hFFF2, 1'b0});
        exp_q.push_back({kn, 4'h0, 16'hFFF2, 1'b0});
        step({km, 4'hB, 16'hFFE4, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h42);
        {int_mask_i, halt_i} = 2'b11;
        step({kn, 4'h0, 16'hFFF2, 1'b1}, 8'h00, 8'h00, 6'h00, 7'h01);
        halt_i = 1'b0;
        step({kn, 4'h0, 16'hFFF2, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        int_mask_i = 1'b0;
        exp_q.push_back({kn, 4'h0, 16'hFFF4, 1'b0});
        step({km, 4'h3, 16'hFFF4, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        trap_req_i = 1'b1;
        step({kt, 4'h0, 16'hFFFC, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        halt_i = 1'b1;
        step({kn, 4'h0, 16'hFFFC, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        reset_req_i = 1'b1;
        step({kr, 4'h0, 16'hFFFE, 1'b1}, 8'h00, 8'h00, 6'h00, 7'h00);
        halt_i = 1'b0;
        step({kr, 4'h0, 16'hFFFE, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        {reset_req_i, trap_req_i} = 2'b00;
        step({kn, 4'h0, 16'hFFFE, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        // Port C on group 0, then on group 1 after a second reset
        rnd = xs(rnd);
        step({km, 4'h0, 16'hFFFA, 1'b0}, 8'h00, 8'h00, rnd[5:0] | 6'h01, 7'h00);
        step({kn, 4'h0, 16'hFFFA, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        rst_n_i = 1'b0;
        pc_group_opt_i = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        step({kn, 4'h0, 16'hFFFE, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        rnd = xs(rnd);
        step({km, 4'h1, 16'hFFF8, 1'b0}, 8'h00, 8'h00, rnd[5:0] | 6'h01, 7'h00);
        halt_i = 1'b1;
        step({km, 4'h1, 16'hFFF8, 1'b1}, 8'h00, rnd[15:8] | 8'h80, 6'h00, 7'h00);
        step({km, 4'h0, 16'hFFFA, 1'b1}, rnd[7:0] | 8'h01, 8'hFF, 6'h00, 7'h00);
        step({kn, 4'h0, 16'hFFFA, 1'b0}, 8'h00, 8'h00, 6'h00, 7'h00);
        end_of_test();
    end
endmodule : tb_ivpm_top

`default_nettype wire
